// ===== gpm_pkg.sv
package gpm_pkg;
	// Register indices; byte address on the bus is four times the index
	localparam logic [5:0] IDX_PORT_A_DATA            = 6'h01;
	localparam logic [5:0] IDX_PORT_A_DIRECTION       = 6'h04;
	localparam logic [5:0] IDX_PORT_B_DATA            = 6'h0c;
	localparam logic [5:0] IDX_PORT_B_FUNCTION_SECOND = 6'h0d;
	localparam logic [5:0] IDX_PORT_B_DIRECTION       = 6'h0e;
	localparam logic [5:0] IDX_PORT_B_FUNCTION        = 6'h0f;
	localparam logic [5:0] IDX_PORT_C_DATA            = 6'h10;
	localparam logic [5:0] IDX_PORT_C_FUNCTION_SECOND = 6'h11;
	localparam logic [5:0] IDX_PORT_C_DIRECTION       = 6'h12;
	localparam logic [5:0] IDX_PORT_C_FUNCTION        = 6'h13;
	localparam logic [5:0] IDX_OPEN_DRAIN_ENABLE      = 6'h20;

	localparam int ADDR_W  = 8;
	localparam int DATA_W  = 32;
	localparam int A_W     = 8;
	localparam int NARROW_W = 4;

	// Values after reset
	localparam logic [7:0] RST_PORT_A_LATCH  = 8'h00;
	localparam logic [7:0] RST_PORT_A_DIR    = 8'h00;
	localparam logic [3:0] RST_NARROW_LATCH  = 4'hf;
	localparam logic [3:0] RST_NARROW_CFG    = 4'h0;
	localparam logic [7:0] RST_OPEN_DRAIN    = 8'h00;

	// Open-drain enable bit positions
	localparam int OD_B0 = 0;
	localparam int OD_B1 = 1;
	localparam int OD_C1 = 2;

	// Port b role codes, {second function, function, direction}
	localparam logic [2:0] PB_IN      = 3'h0;
	localparam logic [2:0] PB_OUT     = 3'h1;
	localparam logic [2:0] PB_CAPTURE = 3'h2;
	localparam logic [2:0] PB_TIMER   = 3'h3;
	localparam logic [2:0] PB_SERIAL  = 3'h5;
endpackage

// ===== gpm_ports.sv
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
// Notes on behaviour
// - Each port a pin is an input when its direction bit is 0, output when 1.
// - Reset clears port a output latch and direction, so all pins are inputs.
// - Reading a data register returns the pin levels, not the output latch.
// - Port b leaves reset with pins as inputs and its latch all ones.
// - Reset clears port b direction, function and second function registers.
// - Port b bits of the three config registers jointly pick each pin's role.
// - Code 0,1,0 routes port b pins 0 and 1 to capture and interrupt inputs.
// - Code 0,1,1 makes port b pins 2 and 3 drive the timer outputs.
// - Code 1,0,1 puts serial bus data on pin 0, serial bus clock on pin 1.
// - Port b pins 0 and 1 go open-drain under the open-drain enable register.
// - Port c resets to inputs with pull-ups on and its latch all ones.
// - Reset clears port c direction, function and second function registers.
// - On an input port c pin the latch bit switches the pull-up.
// - Port c function output: pin 0 clock out, pin 1 transmit, pin 3 serial clock.
// - Port c pin 2 always feeds receive; pin 3 as input feeds both serial clock and clear-to-send.
module gpm_ports (
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	input  wire logic                        ce_i,
	input  wire logic                        psel_i,
	input  wire logic                        penable_i,
	input  wire logic                        pwrite_i,
	input  wire logic [gpm_pkg::ADDR_W-1:0]  paddr_i,
	input  wire logic [gpm_pkg::DATA_W-1:0]  pwdata_i,
	output logic      [gpm_pkg::DATA_W-1:0]  prdata_o,
	output logic                             pready_o,
	output logic                             pslverr_o,
	input  wire logic [gpm_pkg::A_W-1:0]     pa_in_i,
	output logic      [gpm_pkg::A_W-1:0]     pa_out_o,
	output logic      [gpm_pkg::A_W-1:0]     pa_oe_n_o,
	input  wire logic [gpm_pkg::NARROW_W-1:0] pb_in_i,
	output logic      [gpm_pkg::NARROW_W-1:0] pb_out_o,
	output logic      [gpm_pkg::NARROW_W-1:0] pb_oe_n_o,
	input  wire logic [gpm_pkg::NARROW_W-1:0] pc_in_i,
	output logic      [gpm_pkg::NARROW_W-1:0] pc_out_o,
	output logic      [gpm_pkg::NARROW_W-1:0] pc_oe_n_o,
	output logic      [gpm_pkg::NARROW_W-1:0] pc_pullup_o,
	output logic                             timer_capture_in_a_o,
	output logic                             timer_capture_in_b_o,
	output logic                             ext_irq_line_a_o,
	output logic                             ext_irq_line_b_o,
	input  wire logic                        timer_out_a_i,
	input  wire logic                        timer_out_b_i,
	input  wire logic                        serial_bus_data_drive_i,
	input  wire logic                        serial_bus_clock_drive_i,
	output logic                             serial_bus_data_o,
	output logic                             serial_bus_clock_o,
	input  wire logic                        uart_transmit_i,
	input  wire logic                        uart_serial_clock_drive_i,
	input  wire logic                        system_clock_out_i,
	output logic                             uart_receive_o,
	output logic                             uart_serial_clock_o,
	output logic                             uart_clear_to_send_o
);
	import gpm_pkg::*;

	// Software-visible state
	logic [A_W-1:0]      pa_latch_q;
	logic [A_W-1:0]      pa_dir_q;
	logic [NARROW_W-1:0] pb_latch_q;
	logic [NARROW_W-1:0] pb_dir_q;
	logic [NARROW_W-1:0] pb_fn_q;
	logic [NARROW_W-1:0] pb_fn2_q;
	logic [NARROW_W-1:0] pc_latch_q;
	logic [NARROW_W-1:0] pc_dir_q;
	logic [NARROW_W-1:0] pc_fn_q;
	logic [NARROW_W-1:0] pc_fn2_q;
	logic [7:0]          od_q;

	// Bus handshake state
	logic              pready_q;
	logic              pslverr_q;
	logic [DATA_W-1:0] prdata_q;
	logic              access;
	logic              wr_en;
	logic [5:0]        idx;
	logic              hit;
	logic [DATA_W-1:0] rd_d;

	// Next values of the pin and peripheral outputs
	logic [NARROW_W-1:0] pb_out_d;
	logic [NARROW_W-1:0] pb_oe_n_d;
	logic [NARROW_W-1:0] pc_out_d;
	logic [NARROW_W-1:0] pc_oe_n_d;
	logic [NARROW_W-1:0] pc_pullup_d;
	logic [NARROW_W-1:0] pb_od;
	logic [2:0]          pb_role [NARROW_W];
	logic                cap_a_d;
	logic                cap_b_d;
	logic                sb_data_d;
	logic                sb_clock_d;
	logic                uclk_d;

	assign access = psel_i && penable_i;
	assign idx    = paddr_i[7:2];
	assign wr_en  = access && pwrite_i && pready_q;

	// Address decode and read mux; write-only registers read as zero
	always_comb begin
		hit  = 1'b1;
		rd_d = '0;
		case (idx)
			IDX_PORT_A_DATA: rd_d = {24'h0, pa_in_i};
			IDX_PORT_B_DATA: rd_d = {28'h0, pb_in_i};
			IDX_PORT_C_DATA: rd_d = {28'h0, pc_in_i};
			IDX_PORT_A_DIRECTION,
			IDX_PORT_B_FUNCTION_SECOND,
			IDX_PORT_B_DIRECTION,
			IDX_PORT_B_FUNCTION,
			IDX_PORT_C_FUNCTION_SECOND,
			IDX_PORT_C_DIRECTION,
			IDX_PORT_C_FUNCTION,
			IDX_OPEN_DRAIN_ENABLE: rd_d = '0;
			default: hit = 1'b0;
		endcase
	end

	// One wait state: answer comes on the second access-phase edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
		end else if (ce_i) begin
			pready_q  <= access && !pready_q;
			pslverr_q <= access && !pready_q && !hit;
			prdata_q  <= (access && !pready_q && !pwrite_i) ? rd_d : '0;
		end
	end

	// Port a registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pa_latch_q <= RST_PORT_A_LATCH;
			pa_dir_q   <= RST_PORT_A_DIR;
		end else if (ce_i && wr_en) begin
			if (idx == IDX_PORT_A_DATA)
				pa_latch_q <= pwdata_i[7:0];
			if (idx == IDX_PORT_A_DIRECTION)
				pa_dir_q <= pwdata_i[7:0];
		end
	end

	// Port b registers; only the low nibble is stored
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pb_latch_q <= RST_NARROW_LATCH;
			pb_dir_q   <= RST_NARROW_CFG;
			pb_fn_q    <= RST_NARROW_CFG;
			pb_fn2_q   <= RST_NARROW_CFG;
		end else if (ce_i && wr_en) begin
			if (idx == IDX_PORT_B_DATA)
				pb_latch_q <= pwdata_i[3:0];
			if (idx == IDX_PORT_B_DIRECTION)
				pb_dir_q <= pwdata_i[3:0];
			if (idx == IDX_PORT_B_FUNCTION)
				pb_fn_q <= pwdata_i[3:0];
			if (idx == IDX_PORT_B_FUNCTION_SECOND)
				pb_fn2_q <= {2'h0, pwdata_i[1:0]};
		end
	end

	// Port c registers; function register is held but steers no pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_latch_q <= RST_NARROW_LATCH;
			pc_dir_q   <= RST_NARROW_CFG;
			pc_fn_q    <= RST_NARROW_CFG;
			pc_fn2_q   <= RST_NARROW_CFG;
		end else if (ce_i && wr_en) begin
			if (idx == IDX_PORT_C_DATA)
				pc_latch_q <= pwdata_i[3:0];
			if (idx == IDX_PORT_C_DIRECTION)
				pc_dir_q <= pwdata_i[3:0];
			if (idx == IDX_PORT_C_FUNCTION)
				pc_fn_q <= pwdata_i[3:0];
			if (idx == IDX_PORT_C_FUNCTION_SECOND)
				pc_fn2_q <= {pwdata_i[3], 1'b0, pwdata_i[1:0]};
		end
	end

	// Open-drain enables
	always_ff @(posedge clk_i) begin
		if (rst_i)
			od_q <= RST_OPEN_DRAIN;
		else if (ce_i && wr_en && idx == IDX_OPEN_DRAIN_ENABLE)
			od_q <= pwdata_i[7:0];
	end

	assign pb_od = {2'b00, od_q[OD_B1], od_q[OD_B0]};

	// Port b role per pin; reserved codes leave the pin as a plain input
	for (genvar i = 0; i < NARROW_W; i++) begin : g_pb
		logic val;
		logic drv;
		assign pb_role[i] = {pb_fn2_q[i], pb_fn_q[i], pb_dir_q[i]};
		always_comb begin
			val = 1'b1;
			drv = 1'b0;
			case (pb_role[i])
				PB_OUT: begin
					val = pb_latch_q[i];
					drv = 1'b1;
				end
				PB_TIMER: begin
					val = (i == 2) ? timer_out_a_i : timer_out_b_i;
					drv = (i >= 2);
				end
				PB_SERIAL: begin
					val = (i == 0) ? serial_bus_data_drive_i : serial_bus_clock_drive_i;
					drv = (i <= 1);
				end
				default: begin
					val = 1'b1;
					drv = 1'b0;
				end
			endcase
		end
		// Open-drain pins only pull low and release for a one; one driver per bit
		assign pb_out_d[i]  = val;
		assign pb_oe_n_d[i] = !(drv && !(pb_od[i] && val));
	end

	// Port c pins: {second function, direction} picks the role
	always_comb begin
		pc_out_d    = pc_latch_q;
		pc_oe_n_d   = ~pc_dir_q;
		pc_pullup_d = pc_latch_q & ~pc_dir_q;
		if (pc_fn2_q[0] && pc_dir_q[0])
			pc_out_d[0] = system_clock_out_i;
		if (pc_fn2_q[1] && pc_dir_q[1])
			pc_out_d[1] = uart_transmit_i;
		if (pc_fn2_q[3] && pc_dir_q[3])
			pc_out_d[3] = uart_serial_clock_drive_i;
		// Reserved code with direction low stays an undriven input
		if (od_q[OD_C1] && pc_out_d[1])
			pc_oe_n_d[1] = 1'b1;
	end

	// Peripheral inputs idle low for capture, high for bus lines
	always_comb begin
		cap_a_d    = (pb_role[0] == PB_CAPTURE) && pb_in_i[0];
		cap_b_d    = (pb_role[1] == PB_CAPTURE) && pb_in_i[1];
		sb_data_d  = (pb_role[0] == PB_SERIAL) ? pb_in_i[0] : 1'b1;
		sb_clock_d = (pb_role[1] == PB_SERIAL) ? pb_in_i[1] : 1'b1;
		uclk_d     = pc_dir_q[3] ? 1'b1 : pc_in_i[3];
	end

	// Every output leaves a flop; adds one cycle of pin latency
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pa_out_o             <= RST_PORT_A_LATCH;
			pa_oe_n_o            <= '1;
			pb_out_o             <= RST_NARROW_LATCH;
			pb_oe_n_o            <= '1;
			pc_out_o             <= RST_NARROW_LATCH;
			pc_oe_n_o            <= '1;
			pc_pullup_o          <= RST_NARROW_LATCH;
			timer_capture_in_a_o <= 1'b0;
			timer_capture_in_b_o <= 1'b0;
			ext_irq_line_a_o     <= 1'b0;
			ext_irq_line_b_o     <= 1'b0;
			serial_bus_data_o    <= 1'b1;
			serial_bus_clock_o   <= 1'b1;
			uart_receive_o       <= 1'b1;
			uart_serial_clock_o  <= 1'b1;
			uart_clear_to_send_o <= 1'b1;
		end else if (ce_i) begin
			pa_out_o             <= pa_latch_q;
			pa_oe_n_o            <= ~pa_dir_q;
			pb_out_o             <= pb_out_d;
			pb_oe_n_o            <= pb_oe_n_d;
			pc_out_o             <= pc_out_d;
			pc_oe_n_o            <= pc_oe_n_d;
			pc_pullup_o          <= pc_pullup_d;
			timer_capture_in_a_o <= cap_a_d;
			timer_capture_in_b_o <= cap_b_d;
			ext_irq_line_a_o     <= cap_a_d;
			ext_irq_line_b_o     <= cap_b_d;
			serial_bus_data_o    <= sb_data_d;
			serial_bus_clock_o   <= sb_clock_d;
			uart_receive_o       <= pc_in_i[2];
			uart_serial_clock_o  <= uclk_d;
			uart_clear_to_send_o <= uclk_d;
		end
	end

	assign prdata_o  = prdata_q;
	assign pready_o  = pready_q;
	assign pslverr_o = pslverr_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_rd_a;
		access && !pwrite_i && !pready_q && idx == IDX_PORT_A_DATA && ce_i;
	endsequence
	sequence s_reset_ce;
		rst_i ##1 (!rst_i && ce_i);
	endsequence

	property p_dir_a;
		ce_i |=> pa_oe_n_o == ~$past(pa_dir_q);
	endproperty
	a_dir_a: assert property (p_dir_a) else $error("port a enable does not follow direction");

	property p_reset_a;
		disable iff (1'b0) s_reset_ce |=> pa_oe_n_o == 8'hff && pa_out_o == 8'h00;
	endproperty
	a_reset_a: assert property (p_reset_a) else $error("port a not input after reset");

	property p_read_pins;
		s_rd_a |=> pready_o && prdata_o == {24'h0, $past(pa_in_i)};
	endproperty
	a_read_pins: assert property (p_read_pins) else $error("data read not pin level");

	property p_reset_b;
		disable iff (1'b0) s_reset_ce |=> pb_oe_n_o == 4'hf && pb_latch_q == 4'hf;
	endproperty
	a_reset_b: assert property (p_reset_b) else $error("port b reset state wrong");

	property p_reset_c;
		disable iff (1'b0) s_reset_ce |=> pc_oe_n_o == 4'hf && pc_pullup_o == 4'hf;
	endproperty
	a_reset_c: assert property (p_reset_c) else $error("port c reset state wrong");

	property p_serial_clk;
		ce_i && pb_role[1] == PB_SERIAL && !od_q[OD_B1]
			|=> pb_out_o[1] == $past(serial_bus_clock_drive_i) && !pb_oe_n_o[1];
	endproperty
	a_serial_clk: assert property (p_serial_clk) else $error("serial clock not driven");

	property p_capture;
		ce_i && pb_role[0] == PB_CAPTURE |=> timer_capture_in_a_o == $past(pb_in_i[0])
			&& ext_irq_line_a_o == $past(pb_in_i[0]) && pb_oe_n_o[0];
	endproperty
	a_capture: assert property (p_capture) else $error("capture input not routed");

	property p_timer;
		ce_i && pb_role[2] == PB_TIMER |=> pb_out_o[2] == $past(timer_out_a_i) && !pb_oe_n_o[2];
	endproperty
	a_timer: assert property (p_timer) else $error("timer output not driven");

	property p_serial_od;
		ce_i && pb_role[0] == PB_SERIAL && od_q[OD_B0]
			|=> pb_oe_n_o[0] == $past(serial_bus_data_drive_i);
	endproperty
	a_serial_od: assert property (p_serial_od) else $error("serial data open-drain wrong");

	property p_pullup;
		ce_i && !pc_dir_q[0] |=> pc_pullup_o[0] == $past(pc_latch_q[0]);
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up not following latch");

	property p_sysclk;
		ce_i && pc_fn2_q[0] && pc_dir_q[0]
			|=> pc_out_o[0] == $past(system_clock_out_i) && !pc_oe_n_o[0];
	endproperty
	a_sysclk: assert property (p_sysclk) else $error("system clock not on pin");

	property p_receive;
		ce_i |=> uart_receive_o == $past(pc_in_i[2]);
	endproperty
	a_receive: assert property (p_receive) else $error("receive not fed from pin");

	property p_wide_write;
		ce_i && wr_en && idx == IDX_PORT_B_DATA |=> pb_latch_q == $past(pwdata_i[3:0]);
	endproperty
	a_wide_write: assert property (p_wide_write) else $error("narrow latch write wrong");
endmodule // gpm_ports

// ===== gpm_board.sv
`timescale 1ns/1ps
// Board circuitry on the three ports: each pin is the device drive when
// enabled, else the board's own driver, else a port c pull-up or a float
module gpm_board (
	input  wire logic       clk_i,
	input  wire logic       drive_en_i,
	input  wire logic [7:0] pa_drive_i,
	input  wire logic [3:0] pb_drive_i,
	input  wire logic [3:0] pc_drive_i,
	input  wire logic [7:0] pa_out_i,
	input  wire logic [7:0] pa_oe_n_i,
	input  wire logic [3:0] pb_out_i,
	input  wire logic [3:0] pb_oe_n_i,
	input  wire logic [3:0] pc_out_i,
	input  wire logic [3:0] pc_oe_n_i,
	input  wire logic [3:0] pc_pullup_i,
	output logic      [7:0] pa_in_o,
	output logic      [3:0] pb_in_o,
	output logic      [3:0] pc_in_o
);
	logic flip_q = 1'b0;

	// A floating pin changes every cycle so no test leans on a stale level
	always_ff @(posedge clk_i) begin
		flip_q <= ~flip_q;
	end

	// Board drivers are strong and win over a pull-up
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pa_in_o[i] = pa_oe_n_i[i] ? (drive_en_i ? pa_drive_i[i] : flip_q) : pa_out_i[i];
		end
		for (int i = 0; i < 4; i++) begin
			pb_in_o[i] = pb_oe_n_i[i] ? (drive_en_i ? pb_drive_i[i] : flip_q) : pb_out_i[i];
			pc_in_o[i] = pc_oe_n_i[i] ? (drive_en_i ? pc_drive_i[i] :
				(pc_pullup_i[i] ? 1'b1 : flip_q)) : pc_out_i[i];
		end
	end
endmodule // gpm_board

// ===== gpm_ports_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the three ports, driven over APB
module gpm_ports_bench;
	import gpm_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        psel_i = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i = 1'b0;
	logic [7:0]  paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic        pready_o, pslverr_o;
	logic [7:0]  pa_in, pa_out_o, pa_oe_n_o;
	logic [3:0]  pb_in, pb_out_o, pb_oe_n_o, pc_in, pc_out_o, pc_oe_n_o, pc_pullup_o;
	logic        cap_a, cap_b, irq_a, irq_b, sb_dat_o, sb_clk_o, rx_o, sclk_o, cts_o;
	logic        tmr_a = 1'b0, tmr_b = 1'b0, sb_dat = 1'b1, sb_clk = 1'b1;
	logic        tx = 1'b1, sclk_drv = 1'b0, sysclk = 1'b0, ce = 1'b1, brd_en = 1'b1;
	logic [7:0]  brd_a = 8'h96;
	logic [3:0]  brd_b = 4'h0, brd_c = 4'h0;
	logic [31:0] rd;
	logic        err;
	int          mismatches = 0, total_checks = 0, cycles = 0;

	always #20 clk_i = ~clk_i;

	gpm_ports dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.pa_in_i(pa_in), .pa_out_o(pa_out_o), .pa_oe_n_o(pa_oe_n_o),
		.pb_in_i(pb_in), .pb_out_o(pb_out_o), .pb_oe_n_o(pb_oe_n_o),
		.pc_in_i(pc_in), .pc_out_o(pc_out_o), .pc_oe_n_o(pc_oe_n_o), .pc_pullup_o(pc_pullup_o),
		.timer_capture_in_a_o(cap_a), .timer_capture_in_b_o(cap_b),
		.ext_irq_line_a_o(irq_a), .ext_irq_line_b_o(irq_b),
		.timer_out_a_i(tmr_a), .timer_out_b_i(tmr_b),
		.serial_bus_data_drive_i(sb_dat), .serial_bus_clock_drive_i(sb_clk),
		.serial_bus_data_o(sb_dat_o), .serial_bus_clock_o(sb_clk_o),
		.uart_transmit_i(tx), .uart_serial_clock_drive_i(sclk_drv),
		.system_clock_out_i(sysclk), .uart_receive_o(rx_o),
		.uart_serial_clock_o(sclk_o), .uart_clear_to_send_o(cts_o));

	gpm_board board (.clk_i(clk_i), .drive_en_i(brd_en), .pa_drive_i(brd_a), .pb_drive_i(brd_b),
		.pc_drive_i(brd_c), .pa_out_i(pa_out_o), .pa_oe_n_i(pa_oe_n_o), .pb_out_i(pb_out_o),
		.pb_oe_n_i(pb_oe_n_o), .pc_out_i(pc_out_o), .pc_oe_n_i(pc_oe_n_o),
		.pc_pullup_i(pc_pullup_o), .pa_in_o(pa_in), .pb_in_o(pb_in), .pc_in_o(pc_in));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			mismatches++;
		end
	endtask

	// One transfer; outputs move by NBA, so at the edge pready still shows its settled value
	task automatic apb(input logic [5:0] idx, input logic wr, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= {idx, 2'b00};
		pwdata_i <= wd;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		// One wait state: the answer stands at the second access-phase edge
		chk(32'(n), 32'h2);
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	// Register to pin takes one clock, pin to peripheral one more
	task automatic settle;
		repeat (3) @(posedge clk_i);
	endtask

	task automatic t_reset;
		chk(32'({pa_out_o, pa_oe_n_o}), 32'h00ff);
		chk(32'({pb_out_o, pb_oe_n_o}), 32'hff);
		chk(32'({pc_out_o, pc_oe_n_o, pc_pullup_o}), 32'hfff);
		apb(IDX_PORT_A_DATA, 1'b0, 32'h0);
		chk(rd, 32'h96);
		apb(IDX_PORT_B_DIRECTION, 1'b0, 32'h0);
		chk(rd, 32'h0);
		chk(32'({cap_b, irq_b, cap_a, irq_a, sb_clk_o, sb_dat_o}), 32'h3);
		chk(32'({pc_oe_n_o, sclk_o, cts_o}), 32'h3c);
	endtask

	task automatic t_port_a;
		apb(IDX_PORT_A_DIRECTION, 1'b1, 32'h3c);
		apb(IDX_PORT_A_DATA, 1'b1, 32'ha5);
		settle();
		chk(32'({pa_oe_n_o, pa_out_o}), 32'hc3a5);
		apb(IDX_PORT_A_DATA, 1'b0, 32'h0);
		chk(rd, 32'((8'ha5 & 8'h3c) | (brd_a & 8'hc3)));
	endtask

	task automatic t_port_b;
		apb(IDX_PORT_B_DIRECTION, 1'b1, 32'hf0);
		apb(IDX_PORT_B_FUNCTION, 1'b1, 32'h3);
		brd_b <= 4'h1;
		settle();
		chk(32'(pb_oe_n_o), 32'hf);
		chk(32'({cap_b, irq_b, cap_a, irq_a}), 32'h3);
		brd_b <= 4'h2;
		settle();
		chk(32'({cap_b, irq_b, cap_a, irq_a}), 32'hc);
		tmr_a <= 1'b1;
		apb(IDX_PORT_B_FUNCTION, 1'b1, 32'hf);
		apb(IDX_PORT_B_DIRECTION, 1'b1, 32'hf);
		settle();
		chk(32'(pb_oe_n_o), 32'h3);
		chk(32'(pb_out_o[3:2]), 32'h1);
		sb_dat <= 1'b0;
		apb(IDX_PORT_B_FUNCTION_SECOND, 1'b1, 32'h3);
		apb(IDX_PORT_B_FUNCTION, 1'b1, 32'h0);
		apb(IDX_PORT_B_DIRECTION, 1'b1, 32'h3);
		settle();
		chk(32'({pb_oe_n_o[1:0], pb_out_o[1:0]}), 32'h2);
		chk(32'({sb_clk_o, sb_dat_o}), 32'h2);
		// Data released high while another bus device pulls the wire low
		sb_dat <= 1'b1;
		sb_clk <= 1'b0;
		brd_b <= 4'h0;
		apb(IDX_OPEN_DRAIN_ENABLE, 1'b1, 32'h3);
		settle();
		chk(32'(pb_oe_n_o[1:0]), 32'h1);
		chk(32'({sb_clk_o, sb_dat_o}), 32'h0);
	endtask

	task automatic t_port_c;
		brd_c <= 4'h4;
		apb(IDX_PORT_C_DATA, 1'b1, 32'h5);
		settle();
		chk(32'(pc_pullup_o), 32'h5);
		chk(32'({sclk_o, cts_o, rx_o}), 32'h1);
		// With the board's drivers off the pulled-up pins read high; the other pins float
		brd_en <= 1'b0;
		apb(IDX_PORT_C_DATA, 1'b0, 32'h0);
		chk(rd & 32'h5, 32'h5);
		brd_en <= 1'b1;
		sysclk <= 1'b1;
		tx <= 1'b0;
		sclk_drv <= 1'b1;
		apb(IDX_PORT_C_FUNCTION_SECOND, 1'b1, 32'hb);
		apb(IDX_PORT_C_DIRECTION, 1'b1, 32'hb);
		settle();
		chk(32'({pc_oe_n_o, pc_out_o & 4'hb}), 32'h49);
		chk(32'(rx_o), 32'h1);
		tx <= 1'b1;
		apb(IDX_OPEN_DRAIN_ENABLE, 1'b1, 32'h4);
		settle();
		chk(32'(pc_oe_n_o), 32'h6);
	endtask

	// Clock enable low holds pin and peripheral outputs; no bus traffic meanwhile
	task automatic t_freeze;
		ce <= 1'b0;
		tx <= 1'b0;
		brd_c <= 4'h0;
		settle();
		chk(32'({pc_out_o[1], rx_o}), 32'h3);
		ce <= 1'b1;
		settle();
		chk(32'({pc_out_o[1], rx_o}), 32'h0);
	endtask

	// Unmapped place is refused; a write-only register reads zero
	task automatic t_bus;
		apb(6'h3f, 1'b1, 32'hff);
		chk(32'(err), 32'h1);
		apb(6'h3f, 1'b0, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		apb(IDX_PORT_C_DIRECTION, 1'b0, 32'h0);
		chk({rd[30:0], err}, 32'h0);
	endtask

	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// A hang costs at most a few thousand cycles; the tests need well under one thousand
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			end_sim();
		end
	end

	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_port_a();
		t_port_b();
		t_port_c();
		t_freeze();
		t_bus();
		end_sim();
	end
endmodule // gpm_ports_bench
